// *** hw/video_route_pkg.sv ***
package video_route_pkg;

  // Register offsets on the control port.
  localparam logic [7:0] REG_CONV01 = 8'hc3;
  localparam logic [7:0] REG_MANUAL_CONV2 = 8'hc4;
  localparam logic [7:0] REG_CONV3 = 8'hf3;
  localparam logic [7:0] REG_AUTO_ROUTE = 8'hc5;
  localparam logic [7:0] REG_OUT_CFG = 8'hc6;
  localparam logic [7:0] REG_VBI_DATA = 8'hc7;
  localparam logic [7:0] REG_STATUS = 8'hc8;

  // Field positions and reset values.
  localparam int MANUAL_EN_BIT = 7;
  localparam int OUT_EN_BIT = 3;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Control port device addresses (7-bit form of 0x40 and 0x42).
  localparam logic [6:0] CTRL_ADDR_LOW = 7'h20;
  localparam logic [6:0] CTRL_ADDR_HIGH = 7'h21;

  // Converter source codes.
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_AIN1 = 4'h1;
  localparam logic [3:0] CODE_AIN2 = 4'h2;
  localparam logic [3:0] CODE_AIN3 = 4'hc;
  localparam logic [3:0] CODE_AIN4 = 4'h4;
  localparam logic [3:0] CODE_AIN5 = 4'h5;
  localparam logic [3:0] CODE_AIN6 = 4'h6;

  localparam int SYNC_STAGES = 3;
  localparam int FIFO_DEPTH_DEFAULT = 16;

  typedef enum logic [2:0] {
    AUTO_CVBS, AUTO_YC, AUTO_SD_YUV, AUTO_CP_YUV, AUTO_SCART, AUTO_GRAPHICS
  } auto_route_e;

  typedef enum logic [2:0] {
    FMT_SD8, FMT_SD10, FMT_16, FMT_20, FMT_DDR8, FMT_DDR_RGB12
  } out_format_e;

  typedef logic [5:0] ain_sel_t;

  // One processed pixel: YC uses data[19:10]=luma, data[9:0]=chroma;
  // RGB uses data[23:16]=red, data[15:8]=green, data[7:0]=blue.
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic field_or_data_valid;
    logic [23:0] data;
  } pix_word_s;

  localparam int PIX_W = $bits(pix_word_s);

endpackage : video_route_pkg

// *** hw/video_route_out.sv ***

////////////////////////////////////////////////////////////////////////////////
// Clock-crossing pixel FIFO with gray-coded pointers.
module pix_cdc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  // Write side
  input wire logic wclk_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic wvalid_i,
  output logic wready_o,
  // Read side
  input wire logic rclk_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Reset
  input wire logic resetn_i
);
  import video_route_pkg::*;
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two, at least 4");
  end

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wbin_q, rbin_q, wgray_q, rgray_q;
  logic [AW:0] rgray_w_q [SYNC_STAGES];
  logic [AW:0] wgray_r_q [SYNC_STAGES];
  logic [AW:0] wbin_d, rbin_d;
  logic wr_en, rd_en;

  // The pointers are gray coded, so only one bit moves per step and a
  // stale sample is merely conservative, never wrong.
  assign wready_o = (wgray_q != {~rgray_w_q[SYNC_STAGES-1][AW:AW-1],
                                 rgray_w_q[SYNC_STAGES-1][AW-2:0]});
  assign rvalid_o = (rgray_q != wgray_r_q[SYNC_STAGES-1]);
  assign wr_en = wvalid_i && wready_o;
  assign rd_en = rvalid_o && rready_i;
  assign wbin_d = wbin_q + (AW+1)'(wr_en);
  assign rbin_d = rbin_q + (AW+1)'(rd_en);
  assign rdata_o = mem_q[rbin_q[AW-1:0]];

  always_ff @(posedge wclk_i) begin
    if (wr_en) begin
      mem_q[wbin_q[AW-1:0]] <= wdata_i;
    end
  end

  always_ff @(posedge wclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wbin_q <= '0;
      wgray_q <= '0;
      rgray_w_q <= '{default: '0};
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= bin2gray(wbin_d);
      // Stage 0 takes the far pointer; only the last stage is read.
      rgray_w_q[0] <= rgray_q;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        rgray_w_q[i] <= rgray_w_q[i-1];
      end
    end
  end

  always_ff @(posedge rclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rbin_q <= '0;
      rgray_q <= '0;
      wgray_r_q <= '{default: '0};
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= bin2gray(rbin_d);
      wgray_r_q[0] <= wgray_q;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        wgray_r_q[i] <= wgray_r_q[i-1];
      end
    end
  end

  chk_fifo_full_blocks: assert property (@(posedge wclk_i) disable iff (!resetn_i)
    (wbin_q - rbin_q) == (AW+1)'(DEPTH) |-> !wready_o) else $error("FIFO accepts while full");
endmodule : pix_cdc_fifo

////////////////////////////////////////////////////////////////////////////////
module video_route_out #(
  parameter int FIFO_DEPTH = video_route_pkg::FIFO_DEPTH_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control port pins and address strap
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_lsb_strap_i,
  // Analog switch controls, one-hot input 1..6 per converter
  output video_route_pkg::ain_sel_t [3:0] ain_connect_o,
  // Processed pixels and VBI bytes from the processors
  input wire video_route_pkg::pix_word_s pix_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic [7:0] vbi_byte_i,
  input wire logic vbi_valid_i,
  // Pixel bus on the line-locked clock
  input wire logic line_locked_clock_i,
  output logic [19:0] pix_bus_o,
  output logic hsync_or_csync_o,
  output logic vsync_out_o,
  output logic field_or_data_valid_o
);
  import video_route_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG, ST_WDATA, ST_ACK_WDATA,
    ST_RDATA, ST_RACK
  } i2c_state_e;

  //////////////////////////////////////////////////////////////////////////////
  // Source-select decoding.
  function automatic ain_sel_t ain_decode(input logic [1:0] conv, input logic [3:0] code);
    ain_sel_t sel;
    sel = '0;
    case (code)
      CODE_AIN1: sel = (conv == 2'd0) ? 6'h01 : 6'h00;
      CODE_AIN2: sel = (conv == 2'd0 || conv == 2'd2) ? 6'h02 : 6'h00;
      CODE_AIN3: sel = (conv <= 2'd1) ? 6'h04 : 6'h00;
      CODE_AIN4: sel = 6'h08;
      CODE_AIN5: sel = (conv != 2'd3) ? 6'h10 : 6'h00;
      CODE_AIN6: sel = (conv != 2'd3) ? 6'h20 : 6'h00;
      default: sel = 6'h00;
    endcase
    return sel;
  endfunction : ain_decode

  function automatic logic [3:0] auto_code(input logic [2:0] mode, input logic [1:0] conv);
    logic [3:0] c;
    c = CODE_NONE;
    case (mode)
      AUTO_CVBS: c = (conv == 2'd0) ? CODE_AIN1 : CODE_NONE;
      AUTO_YC: c = (conv == 2'd0) ? CODE_AIN2 : (conv == 2'd1) ? CODE_AIN3 : CODE_NONE;
      AUTO_SCART: begin
        case (conv)
          2'd0: c = CODE_AIN2;
          2'd1: c = CODE_AIN6;
          2'd2: c = CODE_AIN5;
          default: c = CODE_AIN4;
        endcase
      end
      AUTO_SD_YUV, AUTO_CP_YUV, AUTO_GRAPHICS: begin
        case (conv)
          2'd0: c = CODE_AIN6;
          2'd1: c = CODE_AIN5;
          2'd2: c = CODE_AIN4;
          default: c = CODE_NONE;
        endcase
      end
      default: c = CODE_NONE;
    endcase
    return c;
  endfunction : auto_code

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once the second and third stages agree.
  logic [SYNC_STAGES-1:0] scl_s_q, sda_s_q, strap_s_q;
  logic scl_f_q, sda_f_q, scl_f_d, sda_f_d;
  logic strap_q, strap_done_q;

  assign scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  assign sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_s_q <= '1;
      sda_s_q <= '1;
      strap_s_q <= '0;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[SYNC_STAGES-2:0], scl_i};
      sda_s_q <= {sda_s_q[SYNC_STAGES-2:0], sda_i};
      strap_s_q <= {strap_s_q[SYNC_STAGES-2:0], addr_lsb_strap_i};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
    end
  end

  // The strap is caught on the first clock after reset, while its synchroniser still holds its reset 0, and then held for good.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q && strap_s_q[1] == strap_s_q[2]) begin
      strap_q <= strap_s_q[2];
      strap_done_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control port slave.
  i2c_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q, ptr_q, rd_addr, rd_data;
  logic sda_oe_q, rw_q;
  logic scl_rise, scl_fall, i2c_start, i2c_stop, reg_wr;
  logic [6:0] dev_addr;

  assign scl_rise = !scl_f_q && scl_f_d;
  assign scl_fall = scl_f_q && !scl_f_d;
  assign i2c_start = scl_f_q && scl_f_d && sda_f_q && !sda_f_d;
  assign i2c_stop = scl_f_q && scl_f_d && !sda_f_q && sda_f_d;
  assign dev_addr = strap_q ? CTRL_ADDR_HIGH : CTRL_ADDR_LOW;
  assign reg_wr = scl_fall && state_q == ST_WDATA && bit_cnt_q == 4'd8;
  assign rd_addr = (state_q == ST_RACK) ? ptr_q + 8'h01 : ptr_q;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= '0;
      shift_q <= '0;
      ptr_q <= '0;
      sda_oe_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (i2c_start) begin
      state_q <= ST_ADDR;
      bit_cnt_q <= '0;
      sda_oe_q <= 1'b0;
    end else if (i2c_stop) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          shift_q <= {shift_q[6:0], sda_f_q};
          bit_cnt_q <= bit_cnt_q + 4'd1;
        end
        ST_RDATA: bit_cnt_q <= bit_cnt_q + 4'd1;
        ST_RACK: if (sda_f_q) state_q <= ST_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (bit_cnt_q == 4'd8) begin
            if (shift_q[7:1] == dev_addr) begin
              sda_oe_q <= 1'b1;
              rw_q <= shift_q[0];
              state_q <= ST_ACK_ADDR;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_REG: begin
          if (bit_cnt_q == 4'd8) begin
            ptr_q <= shift_q;
            sda_oe_q <= 1'b1;
            state_q <= ST_ACK_REG;
          end
        end
        ST_WDATA: begin
          if (bit_cnt_q == 4'd8) begin
            ptr_q <= ptr_q + 8'h01;
            sda_oe_q <= 1'b1;
            state_q <= ST_ACK_WDATA;
          end
        end
        ST_ACK_ADDR, ST_RACK: begin
          bit_cnt_q <= '0;
          if (state_q == ST_RACK) begin
            ptr_q <= ptr_q + 8'h01;
          end
          if (rw_q) begin
            shift_q <= rd_data;
            sda_oe_q <= !rd_data[7];
            state_q <= ST_RDATA;
          end else begin
            sda_oe_q <= 1'b0;
            state_q <= ST_REG;
          end
        end
        ST_ACK_REG, ST_ACK_WDATA: begin
          sda_oe_q <= 1'b0;
          bit_cnt_q <= '0;
          state_q <= ST_WDATA;
        end
        ST_RDATA: begin
          if (bit_cnt_q == 4'd8) begin
            sda_oe_q <= 1'b0;
            state_q <= ST_RACK;
          end else begin
            sda_oe_q <= !shift_q[3'd7 - bit_cnt_q[2:0]];
          end
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [7:0] conv01_q, manual_conv2_q, conv3_q, auto_route_q, out_cfg_q, vbi_q;
  logic vbi_fresh_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv01_q <= REG_RESET;
      manual_conv2_q <= REG_RESET;
      conv3_q <= REG_RESET;
      auto_route_q <= REG_RESET;
      out_cfg_q <= REG_RESET;
    end else if (reg_wr) begin
      if (ptr_q == REG_CONV01) begin
        conv01_q <= shift_q;
      end else if (ptr_q == REG_MANUAL_CONV2) begin
        manual_conv2_q <= shift_q;
      end else if (ptr_q == REG_CONV3) begin
        conv3_q <= shift_q;
      end else if (ptr_q == REG_AUTO_ROUTE) begin
        auto_route_q <= shift_q;
      end else if (ptr_q == REG_OUT_CFG) begin
        out_cfg_q <= shift_q;
      end
    end
  end

  // A new VBI byte wins over the read that clears the fresh flag.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vbi_q <= REG_RESET;
      vbi_fresh_q <= 1'b0;
    end else if (vbi_valid_i) begin
      vbi_q <= vbi_byte_i;
      vbi_fresh_q <= 1'b1;
    end else if (scl_fall && state_q == ST_RDATA && bit_cnt_q == 4'd8 && ptr_q == REG_VBI_DATA) begin
      vbi_fresh_q <= 1'b0;
    end
  end

  always_comb begin
    if (rd_addr == REG_CONV01) begin
      rd_data = conv01_q;
    end else if (rd_addr == REG_MANUAL_CONV2) begin
      rd_data = manual_conv2_q;
    end else if (rd_addr == REG_CONV3) begin
      rd_data = conv3_q;
    end else if (rd_addr == REG_AUTO_ROUTE) begin
      rd_data = auto_route_q;
    end else if (rd_addr == REG_OUT_CFG) begin
      rd_data = out_cfg_q;
    end else if (rd_addr == REG_VBI_DATA) begin
      rd_data = vbi_q;
    end else if (rd_addr == REG_STATUS) begin
      rd_data = {6'h00, !pix_ready_o, vbi_fresh_q};
    end else begin
      rd_data = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog switch routing.
  logic manual_en;
  logic [3:0][3:0] man_code;
  ain_sel_t [3:0] ain_q;

  assign manual_en = manual_conv2_q[MANUAL_EN_BIT];
  assign man_code = {conv3_q[7:4], manual_conv2_q[3:0], conv01_q[7:4], conv01_q[3:0]};
  assign ain_connect_o = ain_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ain_q <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        ain_q[k] <= ain_decode(2'(k), manual_en ? man_code[k]
                                              : auto_code(auto_route_q[2:0], 2'(k)));
      end
    end
  end

  chk_manual_conv0: assert property (@(posedge clk_i) disable iff (!resetn_i)
    manual_en && conv01_q[3:0] == CODE_AIN3 |=> ain_q[0] == 6'h04)
    else $error("Converter 0 not on input 3");
  chk_conv1_refuse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    manual_en && (conv01_q[7:4] == CODE_AIN1 || conv01_q[7:4] == CODE_AIN2) |=> ain_q[1] == '0)
    else $error("Converter 1 connected on a refused code");
  chk_conv2_route: assert property (@(posedge clk_i) disable iff (!resetn_i)
    manual_en && manual_conv2_q[3:0] == CODE_AIN2 |=> ain_q[2] == 6'h02)
    else $error("Converter 2 not on input 2");
  chk_conv3_only4: assert property (@(posedge clk_i) disable iff (!resetn_i)
    manual_en && conv3_q[7:4] != CODE_AIN4 |=> ain_q[3] == '0)
    else $error("Converter 3 connected on a code other than input 4");
  chk_addr_strap_ack: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(state_q == ST_ACK_ADDR) |-> $past(shift_q[7:1]) == dev_addr && sda_oe_q)
    else $error("Address acknowledged that does not match the strap");
  chk_vbi_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
    vbi_valid_i ##1 !vbi_valid_i && rd_addr == REG_VBI_DATA |-> rd_data == $past(vbi_byte_i, 1))
    else $error("VBI byte not presented for readback");
  cov_manual_route: cover property (@(posedge clk_i) disable iff (!resetn_i)
    manual_en && ain_q[3] == 6'h08);
  cov_reg_read: cover property (@(posedge clk_i) disable iff (!resetn_i)
    state_q == ST_RDATA ##[1:300] state_q == ST_RACK);

  //////////////////////////////////////////////////////////////////////////////
  // Pixel path into the line-locked clock domain.
  pix_word_s fifo_word;
  logic fifo_valid, llc_ready;

  pix_cdc_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wclk_i(clk_i),
    .wdata_i(pix_i),
    .wvalid_i(pix_valid_i),
    .wready_o(pix_ready_o),
    .rclk_i(line_locked_clock_i),
    .rdata_o(fifo_word),
    .rvalid_o(fifo_valid),
    .rready_i(llc_ready),
    .resetn_i(resetn_i)
  );

  // Format and enable are quasi-static; each bit is taken only once stable.
  logic [3:0] cfg_s_q [SYNC_STAGES];
  logic [3:0] cfg_llc_q;
  out_format_e fmt;
  logic [19:0] rise_q, fall_hold_q, fall_q, rise_d, fall_d;
  logic hs_q, vs_q, fde_q;

  assign fmt = out_format_e'(cfg_llc_q[2:0]);
  // Holding off the drain while disabled lets the FIFO fill and stall the source.
  assign llc_ready = cfg_llc_q[OUT_EN_BIT];

  always_ff @(posedge line_locked_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_s_q <= '{default: '0};
      cfg_llc_q <= '0;
    end else begin
      cfg_s_q[0] <= out_cfg_q[3:0];
      for (int i = 1; i < SYNC_STAGES; i++) begin
        cfg_s_q[i] <= cfg_s_q[i-1];
      end
      for (int b = 0; b < 4; b++) begin
        if (cfg_s_q[1][b] == cfg_s_q[2][b]) begin
          cfg_llc_q[b] <= cfg_s_q[2][b];
        end
      end
    end
  end

  always_comb begin
    logic [9:0] y, c;
    logic [7:0] r, g, b;
    y = fifo_word.data[19:10];
    c = fifo_word.data[9:0];
    r = fifo_word.data[23:16];
    g = fifo_word.data[15:8];
    b = fifo_word.data[7:0];
    rise_d = '0;
    fall_d = '0;
    case (fmt)
      FMT_SD8: rise_d = {y[9:2], 12'h000};
      FMT_SD10: rise_d = {y, 10'h000};
      FMT_16: rise_d = {y[9:2], 2'h0, c[9:2], 2'h0};
      FMT_20: rise_d = {y, c};
      FMT_DDR8: begin
        rise_d = {y[9:2], 12'h000};
        fall_d = {c[9:2], 12'h000};
      end
      FMT_DDR_RGB12: begin
        rise_d = {b, g[3:0], 8'h00};
        fall_d = {r[3:0], g[7:4], r[7:4], 8'h00};
      end
      default: rise_d = '0;
    endcase
  end

  always_ff @(posedge line_locked_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_q <= '0;
      fall_hold_q <= '0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      fde_q <= 1'b0;
    end else if (fifo_valid && llc_ready) begin
      rise_q <= rise_d;
      fall_hold_q <= fall_d;
      hs_q <= fifo_word.hsync;
      vs_q <= fifo_word.vsync;
      fde_q <= fifo_word.field_or_data_valid;
    end
  end

  always_ff @(negedge line_locked_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fall_q <= '0;
    end else begin
      fall_q <= fall_hold_q;
    end
  end

  logic ddr_mode;
  assign ddr_mode = (fmt == FMT_DDR8) || (fmt == FMT_DDR_RGB12);
  // The falling half is shown only while the clock is low in double-rate modes.
  assign pix_bus_o = (ddr_mode && !line_locked_clock_i) ? fall_q : rise_q;
  assign hsync_or_csync_o = hs_q;
  assign vsync_out_o = vs_q;
  assign field_or_data_valid_o = fde_q;

  chk_sdr20_layout: assert property (@(posedge line_locked_clock_i) disable iff (!resetn_i)
    fmt == FMT_20 && fifo_valid && llc_ready |=> rise_q == $past(fifo_word.data[19:0]))
    else $error("20-bit word misplaced on the bus");
  chk_rgb_fall_half: assert property (@(posedge line_locked_clock_i) disable iff (!resetn_i)
    fmt == FMT_DDR_RGB12 && fifo_valid && llc_ready |=>
      fall_hold_q[19:8] == {$past(fifo_word.data[19:16]), $past(fifo_word.data[15:12]),
                            $past(fifo_word.data[23:20])})
    else $error("RGB falling half misplaced");
  chk_hold_on_empty: assert property (@(posedge line_locked_clock_i) disable iff (!resetn_i)
    !fifo_valid |=> $stable(rise_q) && $stable(hs_q))
    else $error("Bus changed without a pixel");
  cov_rgb_ddr: cover property (@(posedge line_locked_clock_i) disable iff (!resetn_i)
    fmt == FMT_DDR_RGB12 && fifo_valid ##1 fifo_valid);

endmodule : video_route_out

// *** bench/pixel_sink_model.sv ***
module pixel_sink_model (
  // Line-locked clock
  output logic llc_o,
  // Pixel bus
  input wire logic [19:0] bus_i,
  output logic [19:0] rise_o,
  output logic [19:0] fall_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line-locked clock runs free, as a decoder's pixel clock does.
  initial begin
    llc_o = 1'b0;
    #37;
    forever #80 llc_o = ~llc_o;
  end
  // Each half is taken in the middle of its phase, clear of the edges where the
  // bus and its mux both move.
  always @(posedge llc_o) begin
    #40;
    rise_o <= bus_i;
  end
  always @(negedge llc_o) begin
    #40;
    fall_o <= bus_i;
  end
endmodule : pixel_sink_model

// *** bench/video_route_out_tb.sv ***
module video_route_out_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import video_route_pkg::*;
  logic clk_i, resetn_i, scl, sda_m, sda_oe, line_locked_clock, pv, ready, hs, vs, fd, acked;
  wire sda_w = sda_m & ~sda_oe;
  ain_sel_t [3:0] analog_in_pin;
  pix_word_s pix;
  logic [19:0] bus, rise, fall;
  logic [7:0] vbi_b, rd_byte;
  logic vbi_v;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  video_route_out #(.FIFO_DEPTH(16)) video_route_out_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .addr_lsb_strap_i(1'b0), .ain_connect_o(analog_in_pin), .pix_i(pix),
    .pix_valid_i(pv), .pix_ready_o(ready), .vbi_byte_i(vbi_b), .vbi_valid_i(vbi_v),
    .line_locked_clock_i(line_locked_clock), .pix_bus_o(bus), .hsync_or_csync_o(hs),
    .vsync_out_o(vs), .field_or_data_valid_o(fd));
  pixel_sink_model pixel_sink_model_i (.llc_o(line_locked_clock), .bus_i(bus), .rise_o(rise), .fall_o(fall));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask : tick
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic i2c_byte(input logic [7:0] b);
    for (int i = 7; i >= -1; i--) begin
      sda_m = (i < 0) ? 1'b1 : b[i];
      tick(6);
      scl = 1'b1;
      tick(3);
      if (i < 0) acked = acked & ~sda_w;
      else rd_byte[i] = sda_w;
      tick(3);
      scl = 1'b0;
    end
  endtask : i2c_byte
  task automatic reg_write(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] v);
    acked = 1'b1;
    sda_m = 1'b0;
    tick(6);
    scl = 1'b0;
    i2c_byte({dev, 1'b0});
    i2c_byte(off);
    i2c_byte(v);
    sda_m = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b1;
    tick(6);
  endtask : reg_write
  task automatic reg_read(input logic [7:0] off, output logic [7:0] v);
    acked = 1'b1;
    sda_m = 1'b0;
    tick(6);
    scl = 1'b0;
    i2c_byte({CTRL_ADDR_LOW, 1'b0});
    i2c_byte(off);
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b0;
    tick(6);
    scl = 1'b0;
    i2c_byte({CTRL_ADDR_LOW, 1'b1});
    i2c_byte(8'hff);
    v = rd_byte;
    sda_m = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b1;
    tick(6);
  endtask : reg_read
  task automatic push(input pix_word_s w);
    pix = w;
    pv = 1'b1;
    tick(1);
    pv = 1'b0;
    tick(30);
  endtask : push
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_route;
    logic [3:0] codes [6] = '{4'h1, 4'h2, 4'hc, 4'h4, 4'h5, 4'h6};
    for (int i = 0; i < 6; i++) begin
      reg_write(CTRL_ADDR_LOW, REG_CONV01, {codes[i], codes[i]});
      reg_write(CTRL_ADDR_LOW, REG_CONV3, {codes[i], 4'h0});
      reg_write(CTRL_ADDR_LOW, REG_MANUAL_CONV2, {4'h8, codes[i]});
      tick(2);
      chk(acked, 1'b1);
      chk(analog_in_pin[0], 24'h1 << i);
      chk(analog_in_pin[1], (i >= 2) ? 24'h1 << i : 24'h0);
      chk(analog_in_pin[2], (i == 0 || i == 2) ? 24'h0 : 24'h1 << i);
      chk(analog_in_pin[3], (i == 3) ? 24'h8 : 24'h0);
    end
    reg_write(CTRL_ADDR_HIGH, REG_MANUAL_CONV2, 8'h00);
    tick(2);
    chk(acked, 1'b0);
    chk(analog_in_pin[0], 24'h20);
    reg_write(CTRL_ADDR_LOW, REG_MANUAL_CONV2, 8'h00);
    reg_write(CTRL_ADDR_LOW, REG_AUTO_ROUTE, 8'h04);
    tick(2);
    chk({analog_in_pin[3], analog_in_pin[2], analog_in_pin[1], analog_in_pin[0]}, {6'h08, 6'h10, 6'h20, 6'h02});
    $display("test_route done");
  endtask : test_route
  task automatic test_fill;
    int n = 0;
    pix = {1'b1, 2'b00, 24'h0};
    pv = 1'b1;
    while (ready === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    pv = 1'b0;
    chk(n, 16);
    reg_write(CTRL_ADDR_LOW, REG_OUT_CFG, 8'h0b);
    tick(60);
    chk(ready, 1'b1);
    $display("test_fill done");
  endtask : test_fill
  task automatic test_pix20;
    pix_word_s w;
    w = {1'b1, 2'b01, 4'h0, 10'h2a5, 10'h15a};
    push(w);
    chk(bus, {10'h2a5, 10'h15a});
    chk(hs, 1'b1);
    chk(vs, 1'b0);
    chk(fd, 1'b1);
    reg_write(CTRL_ADDR_LOW, REG_OUT_CFG, 8'h09);
    push(w);
    chk(bus, {10'h2a5, 10'h000});
    reg_write(CTRL_ADDR_LOW, REG_OUT_CFG, 8'h0a);
    push(w);
    chk(bus, {8'ha9, 2'h0, 8'h56, 2'h0});
    reg_write(CTRL_ADDR_LOW, REG_OUT_CFG, 8'h08);
    push(w);
    chk(bus, {8'ha9, 12'h000});
    $display("test_pix20 done");
  endtask : test_pix20
  task automatic test_rgb;
    reg_write(CTRL_ADDR_LOW, REG_OUT_CFG, 8'h0d);
    push({1'b0, 2'b10, 8'ha5, 8'h3c, 8'h96});
    chk(vs, 1'b1);
    chk(rise[19:8], {8'h96, 4'hc});
    chk(fall[19:8], {4'h5, 4'h3, 4'ha});
    chk(hs, 1'b0);
    $display("test_rgb done");
  endtask : test_rgb
  task automatic test_vbi;
    logic [7:0] v;
    vbi_b = 8'h5a;
    vbi_v = 1'b1;
    tick(1);
    vbi_v = 1'b0;
    reg_read(REG_STATUS, v);
    chk(v, 8'h01);
    reg_read(REG_VBI_DATA, v);
    chk(v, 8'h5a);
    reg_read(REG_STATUS, v);
    chk(v, 8'h00);
    $display("test_vbi done");
  endtask : test_vbi
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    resetn_i = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
    pix = '0;
    pv = 1'b0;
    acked = 1'b0;
    vbi_b = 8'h00;
    vbi_v = 1'b0;
    tick(16);
    resetn_i = 1'b1;
    tick(12);
    test_route();
    test_fill();
    test_pix20();
    test_rgb();
    test_vbi();
    results();
  end
endmodule : video_route_out_tb
